// [nast_flash_model.sv]
// Behavioural asynchronous flash device facing the strobe generator
`timescale 1ns/1ps
`default_nettype none
module nast_flash_model #(
  parameter int busy_cyc = 4,
  parameter int hold_cyc = 12
) (
  input  wire logic       clk,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  output logic            ready
);
  logic [7:0] data_reg = 8'h00;
  logic [7:0] last_reg = 8'h00;
  logic [7:0] hold_reg = 8'hFF;
  logic       we_q_reg = 1'b1;
  int         wait_reg = 0;
  always_ff @(posedge clk) begin
    we_q_reg <= we_n;
    if (!ce_n && we_n && !we_q_reg) begin
      last_reg <= din;
      if (!cle && !ale) begin
        data_reg <= din;
      end
      // A command keeps the device busy for a while
      wait_reg <= cle ? busy_cyc : 0;
    end else if (wait_reg > 0) begin
      wait_reg <= wait_reg - 1;
    end
    hold_reg <= !re_n ? 8'h00 : ((hold_reg == 8'hFF) ? 8'hFF : hold_reg + 8'h01);
  end
  assign ready = (wait_reg == 0);
  // Output hold is finite; after it the bus shows garbage, not the old byte
  assign dout = (!ce_n && (!re_n || hold_reg < hold_cyc)) ? data_reg : ~data_reg;
endmodule // nast_flash_model
`default_nettype wire

// [nast_pkg.sv]
// Types for the flash strobe timing generator
`default_nettype none
package nast_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LEAD   = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100,
    ST_CEHOLD = 3'b101,
    ST_RDY    = 3'b110,
    ST_EDO    = 3'b111
  } nast_state_t;
  typedef enum logic [1:0] {
    OP_CMD   = 2'b00,
    OP_ADDR  = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ  = 2'b11
  } nast_op_t;
endpackage
`default_nettype wire

// [nast_regs.svh]
// Register map, field positions, reset values and timing counts
`ifndef NAST_REGS_SVH
`define NAST_REGS_SVH
`define NAST_ADDR_W        8
`define NAST_OFS_TIMING    8'h00
`define NAST_OFS_CTRL      8'h04
`define NAST_OFS_CMD       8'h08
`define NAST_OFS_STATUS    8'h0C
`define NAST_AS_LSB        0
`define NAST_DS_LSB        8
`define NAST_DH_LSB        16
`define NAST_CNT_W         8
`define NAST_EDO_BIT       0
`define NAST_DLY_LSB       4
`define NAST_DLY_W         4
`define NAST_OP_LSB        8
`define NAST_RST_AS        8'h01
`define NAST_RST_DS        8'h02
`define NAST_RST_DH        8'h02
`define NAST_RST_DLY       4'h8
`define NAST_MIN_DS_DH     8'h01
`define NAST_CE_LEAD       8'h01
`define NAST_RDY_EXTRA     8'h01
`define NAST_HIST_W        17
`endif

// [nast_top.sv]
// Asynchronous-mode NAND flash strobe timing generator
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "nast_regs.svh"
`default_nettype none
module nast_top
  import nast_pkg::*;
(
  input  wire logic                   CLOCK,
  input  wire logic                   RSTN,
  input  wire logic [`NAST_ADDR_W-1:0] REG_ADDR,
  input  wire logic [31:0]            REG_WDATA,
  input  wire logic                   REG_WRITE,
  input  wire logic                   REG_READ,
  output logic      [31:0]            REG_RDATA,
  output logic                        FLASH_CHIP_ENABLE_N,
  output logic                        FLASH_CMD_LATCH,
  output logic                        FLASH_ADDR_LATCH,
  output logic                        FLASH_WRITE_STROBE_N,
  output logic                        FLASH_READ_STROBE_N,
  output logic      [7:0]             FLASH_DATA_OUT,
  output logic                        FLASH_DATA_OE,
  input  wire logic [7:0]             FLASH_DATA_IN,
  input  wire logic                   FLASH_READY,
  output logic                        BUSY
);

  logic [`NAST_CNT_W-1:0] address_setup_count_reg;
  logic [`NAST_CNT_W-1:0] data_setup_count_reg;
  logic [`NAST_CNT_W-1:0] data_hold_count_reg;
  logic                   extended_data_out_mode_reg;
  logic [`NAST_DLY_W-1:0] read_sample_delay_reg;
  nast_state_t            state_reg;
  nast_state_t            state_next;
  nast_op_t               op_reg;
  logic [`NAST_CNT_W-1:0] cnt_reg;
  logic [`NAST_CNT_W-1:0] cnt_next;
  logic [7:0]             wdata_reg;
  logic [7:0]             rdata_byte_reg;
  logic                   rvalid_reg;
  logic                   captured_reg;
  logic [`NAST_HIST_W-1:0] re_hist_reg;
  logic [31:0]            rdata_reg;

  wire sel_timing = (REG_ADDR == `NAST_OFS_TIMING);
  wire sel_ctrl   = (REG_ADDR == `NAST_OFS_CTRL);
  wire sel_cmd    = (REG_ADDR == `NAST_OFS_CMD);
  wire sel_status = (REG_ADDR == `NAST_OFS_STATUS);
  wire idle       = (state_reg == ST_IDLE);
  // A command written while busy is dropped without any sign
  wire start      = REG_WRITE & sel_cmd & idle;
  wire [1:0] new_op = REG_WDATA[`NAST_OP_LSB+1:`NAST_OP_LSB];
  wire is_read    = (op_reg == OP_READ);
  wire cnt_zero   = (cnt_reg == '0);

  // Zero would give a strobe with no width, so clamp to one period
  wire [`NAST_CNT_W-1:0] ds_eff = (data_setup_count_reg < `NAST_MIN_DS_DH) ?
                                  `NAST_MIN_DS_DH : data_setup_count_reg;
  wire [`NAST_CNT_W-1:0] dh_eff = (data_hold_count_reg < `NAST_MIN_DS_DH) ?
                                  `NAST_MIN_DS_DH : data_hold_count_reg;
  wire [`NAST_CNT_W-1:0] ds_load = ds_eff - `NAST_MIN_DS_DH;
  wire [`NAST_CNT_W-1:0] dh_load = dh_eff - `NAST_MIN_DS_DH;
  wire [`NAST_CNT_W-1:0] as_load = address_setup_count_reg - `NAST_CE_LEAD;
  // The lead cycle is the extra step; adding here would wrap at the top count
  wire [`NAST_CNT_W-1:0] rr_load = address_setup_count_reg;
  wire as_zero = (address_setup_count_reg == '0);

  // Delayed read strobe, one clock of resolution per step of the field
  wire [4:0] dly_idx  = {1'b0, read_sample_delay_reg};
  wire dly_now  = re_hist_reg[dly_idx];
  wire dly_prev = re_hist_reg[dly_idx + 5'h01];
  wire edo_rise = dly_now & ~dly_prev;
  wire edo_cap  = extended_data_out_mode_reg & edo_rise & is_read & ~captured_reg;
  wire norm_cap = ~extended_data_out_mode_reg & is_read &
                  (state_reg == ST_STROBE) & cnt_zero;

  // Phase sequencer; the setup, strobe and hold phases are down-counters expiring at zero
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          if (new_op == OP_READ) begin
            state_next = ST_RDY;
          end else begin
            state_next = ST_LEAD;
          end
        end
      end
      ST_LEAD: begin
        if (is_read) begin
          // Lead plus AS+1 setup cycles makes the AS+2 wait after ready
          state_next = ST_SETUP;
          cnt_next   = rr_load;
        end else if (as_zero) begin
          state_next = ST_STROBE;
          cnt_next   = ds_load;
        end else begin
          state_next = ST_SETUP;
          cnt_next   = as_load;
        end
      end
      ST_RDY: begin
        if (FLASH_READY) begin
          state_next = ST_LEAD;
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          state_next = ST_STROBE;
          cnt_next   = ds_load;
        end else begin
          cnt_next   = cnt_reg - 8'h01;
        end
      end
      ST_STROBE: begin
        if (cnt_zero) begin
          state_next = ST_HOLD;
          cnt_next   = dh_load;
        end else begin
          cnt_next   = cnt_reg - 8'h01;
        end
      end
      ST_HOLD: begin
        if (!cnt_zero) begin
          cnt_next   = cnt_reg - 8'h01;
        end else if (is_read && extended_data_out_mode_reg) begin
          state_next = ST_EDO;
        end else begin
          state_next = ST_CEHOLD;
        end
      end
      ST_EDO: begin
        // Delay is at most fifteen clocks, so this wait is bounded
        if (captured_reg || edo_cap) begin
          state_next = ST_IDLE;
        end
      end
      ST_CEHOLD: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Pin levels follow the state they will stand in
  wire ce_n_next  = (state_next == ST_IDLE);
  wire latch_ph   = (state_next == ST_SETUP) | (state_next == ST_STROBE) |
                    (state_next == ST_HOLD);
  wire cle_next   = latch_ph & (op_reg == OP_CMD) & ~idle;
  wire ale_next   = latch_ph & (op_reg == OP_ADDR) & ~idle;
  wire strobe_ph  = (state_next == ST_STROBE) & ~idle;
  wire we_n_next  = ~(strobe_ph & ~is_read);
  wire re_n_next  = ~(strobe_ph & is_read);
  wire oe_next    = latch_ph & ~is_read & ~idle;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // One step of every count is one clock period
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      op_reg <= OP_CMD;
    end else if (start) begin
      op_reg <= nast_op_t'(new_op);
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wdata_reg <= 8'h00;
    end else if (start) begin
      wdata_reg <= REG_WDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_CHIP_ENABLE_N <= 1'b1;
    end else begin
      FLASH_CHIP_ENABLE_N <= ce_n_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_CMD_LATCH <= 1'b0;
    end else begin
      FLASH_CMD_LATCH <= cle_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_ADDR_LATCH <= 1'b0;
    end else begin
      FLASH_ADDR_LATCH <= ale_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_WRITE_STROBE_N <= 1'b1;
    end else begin
      FLASH_WRITE_STROBE_N <= we_n_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_READ_STROBE_N <= 1'b1;
    end else begin
      FLASH_READ_STROBE_N <= re_n_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_DATA_OE <= 1'b0;
    end else begin
      FLASH_DATA_OE <= oe_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (state_next != ST_IDLE);
    end
  end

  // Data byte waits in its own flop so it is valid before the strobe falls
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLASH_DATA_OUT <= 8'h00;
    end else if (start) begin
      FLASH_DATA_OUT <= REG_WDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      re_hist_reg <= {`NAST_HIST_W{1'b1}};
    end else begin
      re_hist_reg <= {re_hist_reg[`NAST_HIST_W-2:0], FLASH_READ_STROBE_N};
    end
  end

  // Capture wins over the clear; a start never meets a capture anyway
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_byte_reg <= 8'h00;
      rvalid_reg     <= 1'b0;
      captured_reg   <= 1'b0;
    end else if (edo_cap || norm_cap) begin
      rdata_byte_reg <= FLASH_DATA_IN;
      rvalid_reg     <= 1'b1;
      captured_reg   <= 1'b1;
    end else if (start) begin
      rvalid_reg     <= 1'b0;
      captured_reg   <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      address_setup_count_reg <= `NAST_RST_AS;
    end else if (REG_WRITE && sel_timing) begin
      address_setup_count_reg <= REG_WDATA[`NAST_AS_LSB+:`NAST_CNT_W];
    end
  end

  // Counts land at once, even mid-operation; reprogram only while idle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      data_setup_count_reg <= `NAST_RST_DS;
    end else if (REG_WRITE && sel_timing) begin
      data_setup_count_reg <= REG_WDATA[`NAST_DS_LSB+:`NAST_CNT_W];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      data_hold_count_reg <= `NAST_RST_DH;
    end else if (REG_WRITE && sel_timing) begin
      data_hold_count_reg <= REG_WDATA[`NAST_DH_LSB+:`NAST_CNT_W];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      extended_data_out_mode_reg <= 1'b0;
      read_sample_delay_reg      <= `NAST_RST_DLY;
    end else if (REG_WRITE && sel_ctrl) begin
      extended_data_out_mode_reg <= REG_WDATA[`NAST_EDO_BIT];
      read_sample_delay_reg      <= REG_WDATA[`NAST_DLY_LSB+:`NAST_DLY_W];
    end
  end

  wire [31:0] rd_timing = {8'h00, data_hold_count_reg, data_setup_count_reg,
                           address_setup_count_reg};
  wire [31:0] rd_ctrl   = {24'h000000, read_sample_delay_reg, 3'b000,
                           extended_data_out_mode_reg};
  wire [31:0] rd_cmd    = {22'h000000, op_reg, wdata_reg};
  wire [31:0] rd_status = {16'h0000, rdata_byte_reg, 5'b00000, rvalid_reg,
                           FLASH_READY, ~idle};
  wire [31:0] rd_mux    = sel_timing ? rd_timing :
                          sel_ctrl   ? rd_ctrl   :
                          sel_cmd    ? rd_cmd    :
                          sel_status ? rd_status : 32'h00000000;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 32'h00000000;
    end else if (REG_READ) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign REG_RDATA = rdata_reg;

endmodule // nast_top
`default_nettype wire

// [nast_top_bench.sv]
// Self-checking bench for the flash strobe timing generator
`timescale 1ns/1ps
`include "nast_regs.svh"
`default_nettype none
module nast_top_bench;
  import nast_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        ce_n, cle, ale, we_n, re_n, oe, ready, busy;
  logic [7:0]  dout, flash_q;
  wire  [7:0]  bus;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          c_busy, c_we, c_re, c_oe, c_cle, c_ale, c_post;
  localparam int tset [5][3] = '{'{1, 1, 1}, '{0, 1, 1}, '{2, 3, 4}, '{0, 0, 0}, '{3, 2, 1}};
  always #10 clock = ~clock;
  assign bus = oe ? dout : flash_q;
  nast_top u_dut (.CLOCK(clock), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WRITE(reg_write), .REG_READ(reg_read), .REG_RDATA(reg_rdata),
    .FLASH_CHIP_ENABLE_N(ce_n), .FLASH_CMD_LATCH(cle), .FLASH_ADDR_LATCH(ale),
    .FLASH_WRITE_STROBE_N(we_n), .FLASH_READ_STROBE_N(re_n), .FLASH_DATA_OUT(dout),
    .FLASH_DATA_OE(oe), .FLASH_DATA_IN(bus), .FLASH_READY(ready), .BUSY(busy));
  nast_flash_model u_flash (.clk(clock), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .din(bus), .dout(flash_q), .ready(ready));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Starts one operation and measures its strobes until the unit is idle again
  task automatic run_op(input nast_op_t op, input logic [7:0] b);
    int  i;
    bit  seen_re;
    seen_re = 1'b0;
    {c_busy, c_we, c_re, c_oe, c_cle, c_ale, c_post} = '0;
    reg_wr(`NAST_OFS_CMD, {22'h0, op, b});
    // First look is the cycle right after the command edge, already busy
    for (i = 0; i < 400; i++) begin
      #1;
      if (busy !== 1'b1) break;
      c_busy++;
      c_we += int'(!we_n);
      c_re += int'(!re_n);
      c_oe += int'(oe);
      c_cle += int'(cle);
      c_ale += int'(ale);
      if (!re_n) seen_re = 1'b1;
      else if (seen_re) c_post++;
      @(posedge clock);
    end
    if (i == 400) begin
      check("operation end", 32'h0, 32'h1);
      finish_test();
    end
    check("idle chip enable", {31'h0, ce_n}, 32'h1);
  endtask
  initial begin
    logic [31:0] d;
    int as_v, ds_v, dh_v, span, dly;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    reg_rd(`NAST_OFS_TIMING, d);
    check("timing reset", d, {8'h00, `NAST_RST_DH, `NAST_RST_DS, `NAST_RST_AS});
    reg_rd(`NAST_OFS_CTRL, d);
    check("control reset", d, {24'h0, `NAST_RST_DLY, 4'h0});
    reg_rd(8'h10, d);
    check("unmapped read", d, 32'h0);
    for (int t = 0; t < 5; t++) begin
      reg_wr(`NAST_OFS_TIMING, {8'h00, 8'(tset[t][2]), 8'(tset[t][1]), 8'(tset[t][0])});
      as_v = tset[t][0];
      ds_v = (tset[t][1] == 0) ? 1 : tset[t][1];
      dh_v = (tset[t][2] == 0) ? 1 : tset[t][2];
      span = as_v + ds_v + dh_v;
      for (int o = 0; o < 3; o++) begin
        run_op(nast_op_t'(o), 8'(8'hA0 + t * 3 + o));
        check("busy span", c_busy, span + 2);
        check("write strobe low", c_we, ds_v);
        check("bus drive", c_oe, span);
        check("command latch", c_cle, (o == 0) ? span : 0);
        check("address latch", c_ale, (o == 1) ? span : 0);
        check("byte at flash", u_flash.last_reg, 8'(8'hA0 + t * 3 + o));
      end
    end
    // Timing ends at AS=3, DS=2, DH=1; the command leaves the device busy
    run_op(OP_WRITE, 8'hC3);
    reg_rd(`NAST_OFS_CMD, d);
    check("command readback", d, {22'h0, OP_WRITE, 8'hC3});
    run_op(OP_CMD, 8'h30);
    run_op(OP_READ, 8'h00);
    check("read strobe low", c_re, 2);
    check("read tail", c_post, 2);
    reg_rd(`NAST_OFS_STATUS, d);
    check("read status", d, 32'h0000_C306);
    // Delays zero, typical, and raised as for a long board trace
    for (int k = 0; k < 3; k++) begin
      dly = (k == 2) ? 10 : k * 8;
      reg_wr(`NAST_OFS_CTRL, {24'h0, 4'(dly), 4'h1});
      run_op(OP_WRITE, 8'(8'h5C + k));
      run_op(OP_READ, 8'h00);
      check("delayed capture wait", {31'h0, (c_post - dly) inside {[1:2]}}, 32'h1);
      reg_rd(`NAST_OFS_STATUS, d);
      check("delayed capture", d, {16'h0, 8'(8'h5C + k), 8'h06});
    end
    finish_test();
  end
endmodule // nast_top_bench
`default_nettype wire

// [nast_top_monitor.sv]
// Checker of flash strobe intervals, bound to nast_top
`timescale 1ns/1ps
`include "nast_regs.svh"
`default_nettype none
module nast_top_monitor (
  input wire logic                    CLOCK,
  input wire logic                    RSTN,
  input wire logic [`NAST_ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0]             REG_WDATA,
  input wire logic                    REG_WRITE,
  input wire logic                    FLASH_CHIP_ENABLE_N,
  input wire logic                    FLASH_CMD_LATCH,
  input wire logic                    FLASH_ADDR_LATCH,
  input wire logic                    FLASH_WRITE_STROBE_N,
  input wire logic                    FLASH_READ_STROBE_N,
  input wire logic                    FLASH_DATA_OE,
  input wire logic                    FLASH_READY
);
  logic [7:0]  as_reg, ds_reg, dh_reg;
  logic [15:0] we_lo_reg, re_lo_reg, oe_hi_reg, we_hi_reg, ce_lo_reg, rdy_hi_reg;
  int          as_c, dse, dhe;
  assign as_c = int'(as_reg);
  assign dse = (ds_reg == 8'h00) ? 1 : int'(ds_reg);
  assign dhe = (dh_reg == 8'h00) ? 1 : int'(dh_reg);
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      as_reg <= `NAST_RST_AS;
      ds_reg <= `NAST_RST_DS;
      dh_reg <= `NAST_RST_DH;
      {we_lo_reg, re_lo_reg, oe_hi_reg, we_hi_reg, ce_lo_reg, rdy_hi_reg} <= '0;
    end else begin
      if (REG_WRITE && REG_ADDR == `NAST_OFS_TIMING) begin
        as_reg <= REG_WDATA[7:0];
        ds_reg <= REG_WDATA[15:8];
        dh_reg <= REG_WDATA[23:16];
      end
      // Run lengths up to the previous cycle
      we_lo_reg <= FLASH_WRITE_STROBE_N ? 16'h0000 : we_lo_reg + 16'h0001;
      re_lo_reg <= FLASH_READ_STROBE_N ? 16'h0000 : re_lo_reg + 16'h0001;
      oe_hi_reg <= FLASH_DATA_OE ? oe_hi_reg + 16'h0001 : 16'h0000;
      we_hi_reg <= FLASH_WRITE_STROBE_N ? we_hi_reg + 16'h0001 : 16'h0000;
      ce_lo_reg <= FLASH_CHIP_ENABLE_N ? 16'h0000 : ce_lo_reg + 16'h0001;
      rdy_hi_reg <= FLASH_READY ? rdy_hi_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_we_rise;
    $rose(FLASH_WRITE_STROBE_N);
  endsequence
  sequence s_re_rise;
    $rose(FLASH_READ_STROBE_N);
  endsequence
  chk_we_low_width: assert property (s_we_rise |-> we_lo_reg == dse)
    else $error("write strobe low width wrong");
  chk_ce_lead_time: assert property (s_we_rise |-> ce_lo_reg == as_c + dse + 1)
    else $error("chip enable lead wrong");
  chk_latch_setup: assert property (s_we_rise |-> oe_hi_reg == as_c + dse)
    else $error("latch setup wrong");
  chk_latch_hold: assert property ($fell(FLASH_DATA_OE) |->
    we_hi_reg == dhe && !FLASH_CMD_LATCH && !FLASH_ADDR_LATCH)
    else $error("latch hold wrong");
  chk_ce_trail_time: assert property ($rose(FLASH_CHIP_ENABLE_N) &&
    we_hi_reg < ce_lo_reg |-> we_hi_reg == dhe + 1)
    else $error("chip enable trail wrong");
  chk_re_low_width: assert property (s_re_rise |-> re_lo_reg == dse)
    else $error("read strobe low width wrong");
  chk_ready_wait: assert property ($fell(FLASH_READ_STROBE_N) |-> rdy_hi_reg >= as_c + 2)
    else $error("read strobe too soon after ready");
  chk_strobe_in_ce: assert property (!FLASH_WRITE_STROBE_N || !FLASH_READ_STROBE_N
    |-> !FLASH_CHIP_ENABLE_N)
    else $error("strobe outside chip enable");
endmodule // nast_top_monitor
bind nast_top nast_top_monitor u_mon (.CLOCK(CLOCK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .FLASH_CHIP_ENABLE_N(FLASH_CHIP_ENABLE_N),
  .FLASH_CMD_LATCH(FLASH_CMD_LATCH), .FLASH_ADDR_LATCH(FLASH_ADDR_LATCH),
  .FLASH_WRITE_STROBE_N(FLASH_WRITE_STROBE_N), .FLASH_READ_STROBE_N(FLASH_READ_STROBE_N),
  .FLASH_DATA_OE(FLASH_DATA_OE), .FLASH_READY(FLASH_READY));
`default_nettype wire
